// ==== verilog/vic_controller.sv ====
// Contract
// - flag left set re-requests after return
// - interrupt return clears active level; pop two
// - plain subroutine return leaves level active
// - pending flag one means request pending
// - enable bit one passes request, zero masks
// - priority bit, then fixed polling order
// - external pins vector 0003h/0013h, edge auto-clear
// - first uart shares 0023h, no clear
// - second uart lowest polled at 004Bh
// - timer c sources share 002Bh, kept
// - spi four flags, 0053h, hardware cleared
// - usb four flag registers, 0033h, kept
`timescale 1ns/10ps
`default_nettype none
module vic_controller (
    input wire logic core_clk,
    input wire logic rst,
    input wire vic_pkg::vic_sources_t sources,
    input wire logic [vic_pkg::NUM_SLOTS-1:0] irq_enable,
    input wire logic [vic_pkg::NUM_SLOTS-1:0] irq_priority,
    input wire logic global_enable,
    input wire logic call_ack,
    input wire logic return_from_interrupt,
    input wire logic subroutine_return,
    output vic_pkg::vic_call_t call,
    output vic_pkg::vic_clear_t flag_clear,
    output logic [1:0] stack_pop_bytes,
    output logic active_high,
    output logic active_low,
    output logic [vic_pkg::NUM_SLOTS-1:0] pending_view
);
    import vic_pkg::*;

    logic [NUM_SLOTS-1:0] raw_req;
    logic [NUM_SLOTS-1:0] live_req;
    logic act_high_reg, act_high_next;
    logic act_low_reg, act_low_next;
    vic_call_t call_reg, call_next;
    vic_clear_t clr_reg, clr_next;
    logic [1:0] pop_reg, pop_next;
    logic [3:0] win_slot;
    logic win_found;
    logic win_high;
    logic [NUM_SLOTS-1:0] high_req;
    logic call_taken;
    logic call_withdrawn;
    logic level_blocked;
    logic call_launch;

    always_comb begin
        raw_req = '0;
        raw_req[SLOT_EXT_A] = sources.ext_a_pending;
        raw_req[SLOT_EXT_B] = sources.ext_b_pending;
        raw_req[SLOT_TIMER_A] = sources.timer_a_overflow;
        raw_req[SLOT_TIMER_B] = sources.timer_b_overflow;
        raw_req[SLOT_UART_A] = sources.uart_a_rx_flag | sources.uart_a_tx_flag;
        raw_req[SLOT_TIMER_C] = sources.timer_c_overflow_flag | sources.timer_c_pin_flag;
        raw_req[SLOT_SPI] = |sources.spi_status_reg;
        raw_req[SLOT_USB] = |sources.usb_irq_flag_regs;
        raw_req[SLOT_I2C] = sources.i2c_flag;
        raw_req[SLOT_ADC] = sources.adc_flag;
        raw_req[SLOT_COUNTER_ARRAY] = |sources.counter_array_flags;
        raw_req[SLOT_UART_B] = sources.uart_b_rx_flag | sources.uart_b_tx_flag;
    end

    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot_mask
        assign live_req[g] = raw_req[g] && irq_enable[g] && global_enable;
        assign high_req[g] = live_req[g] && irq_priority[g];
    end
    assign pending_view = raw_req;

    always_comb begin
        win_found = 1'b0;
        win_slot = '0;
        win_high = 1'b0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (high_req[i]) begin
                win_found = 1'b1;
                win_slot = 4'(i);
                win_high = 1'b1;
            end
        end
        if (!win_found) begin
            for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
                if (live_req[i]) begin
                    win_found = 1'b1;
                    win_slot = 4'(i);
                end
            end
        end
    end

    // a call stands until the core takes it or its request is withdrawn
    assign call_taken = call_reg.call_req && call_ack;
    assign call_withdrawn = call_reg.call_req && !call_ack && !live_req[call_reg.call_slot];
    assign level_blocked = act_high_reg || (act_low_reg && !win_high);
    // still-set flag re-requests in the cycle after the return
    // the return cycle is skipped so the closed level is seen first
    assign call_launch = !call_reg.call_req && win_found && !return_from_interrupt && !level_blocked;

    always_comb begin
        act_high_next = act_high_reg;
        act_low_next = act_low_reg;
        if (return_from_interrupt) begin
            if (act_high_reg) begin
                act_high_next = 1'b0;
            end else begin
                act_low_next = 1'b0;
            end
        end
        // taken after the return, so a new level wins a same-cycle clash
        if (call_taken) begin
            if (call_reg.call_high) begin
                act_high_next = 1'b1;
            end else begin
                act_low_next = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            act_high_reg <= 1'b0;
            act_low_reg <= 1'b0;
        end else begin
            act_high_reg <= act_high_next;
            act_low_reg <= act_low_next;
        end
    end

    always_comb begin
        call_next = call_reg;
        if (call_taken || call_withdrawn) begin
            call_next.call_req = 1'b0;
        end else if (call_launch) begin
            call_next.call_req = 1'b1;
            call_next.call_slot = win_slot;
            call_next.call_high = win_high;
            call_next.call_vector = VEC_TABLE[win_slot];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            call_reg <= '0;
        end else begin
            call_reg <= call_next;
        end
    end

    always_comb begin
        clr_next = '0;
        pop_next = '0;
        // return pops two bytes
        // a plain return pops as well; it differs in the level update and in not holding off a new call
        if (return_from_interrupt || subroutine_return) begin
            pop_next = RETURN_BYTES;
        end
        if (call_taken) begin
            case (call_reg.call_slot)
                SLOT_EXT_A: begin
                    clr_next.ext_a = sources.ext_a_edge_mode;
                end
                SLOT_EXT_B: begin
                    clr_next.ext_b = sources.ext_b_edge_mode;
                end
                SLOT_TIMER_A: begin
                    clr_next.timer_a = AUTO_CLEAR_MASK[SLOT_TIMER_A];
                end
                SLOT_TIMER_B: begin
                    clr_next.timer_b = AUTO_CLEAR_MASK[SLOT_TIMER_B];
                end
                SLOT_I2C: begin
                    clr_next.i2c = AUTO_CLEAR_MASK[SLOT_I2C];
                end
                SLOT_SPI: begin
                    clr_next.spi = AUTO_CLEAR_MASK[SLOT_SPI];
                end
                // uart, timer c, usb and adc flags kept
                default: begin
                    clr_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clr_reg <= '0;
            pop_reg <= '0;
        end else begin
            clr_reg <= clr_next;
            pop_reg <= pop_next;
        end
    end

    assign call = call_reg;
    assign flag_clear = clr_reg;
    assign stack_pop_bytes = pop_reg;
    assign active_high = act_high_reg;
    assign active_low = act_low_reg;
endmodule : vic_controller
`default_nettype wire

// ==== verilog/vic_pkg.sv ====
`default_nettype none
package vic_pkg;
    localparam int NUM_SLOTS = 13;
    localparam logic [3:0] SLOT_RESERVED = 4'h0;
    localparam logic [3:0] SLOT_EXT_A = 4'h1;
    localparam logic [3:0] SLOT_TIMER_A = 4'h2;
    localparam logic [3:0] SLOT_EXT_B = 4'h3;
    localparam logic [3:0] SLOT_TIMER_B = 4'h4;
    localparam logic [3:0] SLOT_UART_A = 4'h5;
    localparam logic [3:0] SLOT_TIMER_C = 4'h6;
    localparam logic [3:0] SLOT_SPI = 4'h7;
    localparam logic [3:0] SLOT_USB = 4'h8;
    localparam logic [3:0] SLOT_I2C = 4'h9;
    localparam logic [3:0] SLOT_ADC = 4'ha;
    localparam logic [3:0] SLOT_COUNTER_ARRAY = 4'hb;
    localparam logic [3:0] SLOT_UART_B = 4'hc;

    localparam logic [15:0] VEC_RESERVED = 16'h0063;
    localparam logic [15:0] VEC_EXT_A = 16'h0003;
    localparam logic [15:0] VEC_TIMER_A = 16'h000b;
    localparam logic [15:0] VEC_EXT_B = 16'h0013;
    localparam logic [15:0] VEC_TIMER_B = 16'h001b;
    localparam logic [15:0] VEC_UART_A = 16'h0023;
    localparam logic [15:0] VEC_TIMER_C = 16'h002b;
    localparam logic [15:0] VEC_SPI = 16'h0053;
    localparam logic [15:0] VEC_USB = 16'h0033;
    localparam logic [15:0] VEC_I2C = 16'h0043;
    localparam logic [15:0] VEC_ADC = 16'h003b;
    localparam logic [15:0] VEC_COUNTER_ARRAY = 16'h005b;
    localparam logic [15:0] VEC_UART_B = 16'h004b;

    localparam logic [15:0] VEC_TABLE [NUM_SLOTS] = '{
        VEC_RESERVED, VEC_EXT_A, VEC_TIMER_A, VEC_EXT_B, VEC_TIMER_B, VEC_UART_A, VEC_TIMER_C,
        VEC_SPI, VEC_USB, VEC_I2C, VEC_ADC, VEC_COUNTER_ARRAY, VEC_UART_B};

    // slots whose source flag the controller clears when it vectors
    localparam logic [NUM_SLOTS-1:0] AUTO_CLEAR_MASK = 13'h0294;

    localparam int SPI_FLAG_W = 4;
    localparam int USB_FLAG_REGS = 4;
    localparam int USB_FLAG_W = 8;
    localparam int PCA_FLAG_W = 8;

    localparam logic [1:0] RETURN_BYTES = 2'h2;

    typedef struct packed {
        logic ext_a_pending;
        logic ext_a_edge_mode;
        logic ext_b_pending;
        logic ext_b_edge_mode;
        logic timer_a_overflow;
        logic timer_b_overflow;
        logic uart_a_rx_flag;
        logic uart_a_tx_flag;
        logic timer_c_overflow_flag;
        logic timer_c_pin_flag;
        logic [SPI_FLAG_W-1:0] spi_status_reg;
        logic [USB_FLAG_REGS*USB_FLAG_W-1:0] usb_irq_flag_regs;
        logic i2c_flag;
        logic adc_flag;
        logic [PCA_FLAG_W-1:0] counter_array_flags;
        logic uart_b_rx_flag;
        logic uart_b_tx_flag;
    } vic_sources_t;

    typedef struct packed {
        logic call_req;
        logic [15:0] call_vector;
        logic [3:0] call_slot;
        logic call_high;
    } vic_call_t;

    typedef struct packed {
        logic ext_a;
        logic timer_a;
        logic ext_b;
        logic timer_b;
        logic timer_c;
        logic spi;
        logic i2c;
    } vic_clear_t;
endpackage : vic_pkg
`default_nettype wire

// ==== tb/vic_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
    input wire logic core_clk,
    input wire vic_pkg::vic_call_t call,
    input wire logic [1:0] ack_wait,
    output logic call_ack = 1'h0
);
    logic [1:0] cnt = 2'h0;
    // a slow core is the delay; ack only ever answers a standing call
    always @(negedge core_clk) begin
        call_ack <= call.call_req && cnt == ack_wait;
        cnt <= (call.call_req && cnt != ack_wait) ? cnt + 2'h1 : 2'h0;
    end
endmodule : vic_core_model
`default_nettype wire

// ==== tb/vic_controller_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module vic_controller_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire vic_pkg::vic_sources_t sources,
    input wire logic [vic_pkg::NUM_SLOTS-1:0] irq_enable,
    input wire logic global_enable,
    input wire logic call_ack,
    input wire logic return_from_interrupt,
    input wire logic subroutine_return,
    input wire vic_pkg::vic_call_t call,
    input wire vic_pkg::vic_clear_t flag_clear,
    input wire logic [1:0] stack_pop_bytes,
    input wire logic active_high,
    input wire logic active_low,
    input wire logic [vic_pkg::NUM_SLOTS-1:0] pending_view
);
    import vic_pkg::*;
    logic [NUM_SLOTS-1:0] req_q;
    // one-edge copy, since a new call reflects the inputs seen one edge earlier
    always_ff @(posedge core_clk) req_q <= irq_enable & pending_view & {NUM_SLOTS{global_enable}};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence acked;
        call_ack && call.call_req;
    endsequence
    sequence returned;
        return_from_interrupt && !call_ack;
    endsequence
    pop_on_return_a: assert property (return_from_interrupt |=> stack_pop_bytes == RETURN_BYTES)
        else $error("no pop after return");
    return_closes_a: assert property (returned |=>
        ($past(active_high) ? !active_high && active_low == $past(active_low) : !active_low)) else $error("level kept");
    sub_keeps_a: assert property (subroutine_return && !call_ack && !return_from_interrupt |=>
        $stable(active_high) && $stable(active_low)) else $error("level changed");
    call_masked_a: assert property ($rose(call.call_req) |-> req_q[call.call_slot])
        else $error("masked call");
    vector_map_a: assert property (call.call_req |-> call.call_vector == VEC_TABLE[call.call_slot])
        else $error("wrong vector");
    high_blocks_a: assert property (active_high |-> !call.call_req)
        else $error("call under high");
    low_preempt_a: assert property (active_low && call.call_req |-> call.call_high)
        else $error("low preempts low");
    ack_takes_a: assert property (acked |=> !call.call_req && ($past(call.call_high) ? active_high : active_low))
        else $error("ack not taken");
    ext_clear_a: assert property (acked ##0 (call.call_slot == SLOT_EXT_A && sources.ext_a_edge_mode)
        |=> flag_clear.ext_a) else $error("edge flag kept");
    level_kept_a: assert property (acked ##0 (call.call_slot == SLOT_EXT_A && !sources.ext_a_edge_mode)
        |=> !flag_clear.ext_a) else $error("level flag cleared");
    spi_clear_a: assert property (acked ##0 (call.call_slot == SLOT_SPI) |=> flag_clear.spi)
        else $error("spi flag kept");
    timer_clear_a: assert property (acked ##0 (call.call_slot == SLOT_TIMER_A) |=> flag_clear.timer_a)
        else $error("timer flag kept");
    clear_on_ack_a: assert property (!(call_ack && call.call_req) |=> flag_clear == '0)
        else $error("clear without vectoring");
endmodule : vic_controller_checker
bind vic_controller vic_controller_checker u_vic_controller_checker (.core_clk, .rst, .sources, .irq_enable,
    .global_enable, .call_ack, .return_from_interrupt, .subroutine_return, .call, .flag_clear, .stack_pop_bytes,
    .active_high, .active_low, .pending_view);
`default_nettype wire

// ==== tb/vic_controller_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module vic_controller_test;
    import vic_pkg::*;
    logic core_clk = 1'h0, rst = 1'h1, global_enable = 1'h1, return_from_interrupt = 1'h0, subroutine_return = 1'h0;
    logic [12:0] irq_enable = '0, irq_priority = '0, m, pending_view;
    logic [1:0] ack_wait = 2'h0, stack_pop_bytes;
    logic call_ack, active_high, active_low;
    vic_sources_t sources = '0;
    vic_call_t call;
    vic_clear_t flag_clear, ec;
    int miscompares = 0, checked = 0, cyc = 0, w;
    always #25 core_clk = ~core_clk;
    vic_controller u_vic_controller (.core_clk, .rst, .sources, .irq_enable, .irq_priority, .global_enable,
        .call_ack, .return_from_interrupt, .subroutine_return, .call, .flag_clear, .stack_pop_bytes, .active_high,
        .active_low, .pending_view);
    vic_core_model u_vic_core_model (.core_clk, .call, .ack_wait, .call_ack);
    task print_verdict;
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task chk(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic vic_sources_t mk(logic [12:0] k);
        vic_sources_t v = '0;
        v.ext_a_edge_mode = 1'($urandom);
        v.ext_b_edge_mode = 1'($urandom);
        {v.ext_a_pending, v.timer_a_overflow, v.ext_b_pending, v.timer_b_overflow} = {k[1], k[2], k[3], k[4]};
        {v.uart_a_rx_flag, v.uart_a_tx_flag} = k[5] ? 2'($urandom_range(3, 1)) : 2'h0;
        {v.timer_c_overflow_flag, v.timer_c_pin_flag} = k[6] ? 2'($urandom_range(3, 1)) : 2'h0;
        v.spi_status_reg = k[7] ? 4'($urandom_range(15, 1)) : 4'h0;
        v.usb_irq_flag_regs = k[8] ? 32'h1 << $urandom_range(31) : 32'h0;
        {v.i2c_flag, v.adc_flag} = {k[9], k[10]};
        v.counter_array_flags = k[11] ? 8'($urandom_range(255, 1)) : 8'h0;
        {v.uart_b_rx_flag, v.uart_b_tx_flag} = k[12] ? 2'($urandom_range(3, 1)) : 2'h0;
        return v;
    endfunction : mk
    // high before low, then lowest slot number
    function automatic int win(logic [12:0] req, logic [12:0] pri);
        for (int h = 1; h >= 0; h--)
            for (int s = 1; s < 13; s++)
                if (req[s] && pri[s] == h[0]) return s;
        return 0;
    endfunction : win
    // ends on the edge that takes the ack, before its updates land
    // hardware clears only timers a and b, i2c, spi and edge-mode pins
    function automatic vic_clear_t clr_of(int s, vic_sources_t v);
        vic_clear_t c;
        c = '0;
        c.ext_a = s == 1 && v.ext_a_edge_mode;
        c.ext_b = s == 3 && v.ext_b_edge_mode;
        c.timer_a = s == 2;
        c.timer_b = s == 4;
        c.spi = s == 7;
        c.i2c = s == 9;
        return c;
    endfunction : clr_of
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (call_ack !== 1'h1 && n < 12);
    endtask : wait_ack
    task ret_pulse(logic [1:0] exp);
        @(negedge core_clk) return_from_interrupt = 1'h1;
        @(negedge core_clk) return_from_interrupt = 1'h0;
        chk("pop", 16'(stack_pop_bytes), 16'h2);
        chk("level", 16'({active_high, active_low}), 16'(exp));
    endtask : ret_pulse
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        void'($urandom(32'hb333b150));
        repeat (2) @(negedge core_clk);
        rst = 1'h0;
        for (int i = 0; i < 40; i++) begin
            m = (i < 12) ? 13'h2 << i : 13'($urandom) & 13'h1ffe;
            irq_priority = 13'($urandom);
            irq_enable = (i < 12) ? 13'h1fff : 13'($urandom);
            ack_wait = 2'($urandom);
            sources = mk(m);
            w = win(m & irq_enable, irq_priority);
            ec = clr_of(w, sources);
            wait_ack;
            chk("raw", 16'(pending_view), 16'(m));
            @(negedge core_clk) sources = '0;
            if (w == 0) chk("idle", 16'(call.call_req), 16'h0);
            else chk("vector", call.call_vector, VEC_TABLE[w]);
            chk("clear", 16'(flag_clear), 16'(ec));
            if (w != 0) ret_pulse(2'h0);
        end
        irq_enable = 13'h1fff;
        irq_priority = 13'h0;
        ack_wait = 2'h0;
        sources = mk(13'h40);
        wait_ack;
        @(negedge core_clk) subroutine_return = 1'h1;
        chk("kept clear", 16'(flag_clear), 16'h0);
        @(negedge core_clk) subroutine_return = 1'h0;
        chk("sub pop", 16'(stack_pop_bytes), 16'h2);
        repeat (3) @(negedge core_clk);
        chk("kept", 16'({active_low, call.call_req}), 16'h2);
        ret_pulse(2'h0);
        wait_ack;
        chk("again", 16'(call_ack), 16'h1);
        chk("again vector", call.call_vector, VEC_TIMER_C);
        @(negedge core_clk);
        irq_priority[2] = 1'h1;
        sources.timer_a_overflow = 1'h1;
        wait_ack;
        chk("nest", call.call_vector, VEC_TIMER_A);
        @(negedge core_clk) sources = '0;
        chk("nest clear", 16'(flag_clear), 16'(clr_of(2, sources)));
        ret_pulse(2'h1);
        ret_pulse(2'h0);
        print_verdict;
    end
endmodule : vic_controller_test
`default_nettype wire
